//--- logic/tpo_defs.svh
// Purpose: constants of the 16-bit pulse timer (offsets, fields, counts)
// Assumes: included by bare name; AHB-Lite word registers
// Notes:   definitions only
`ifndef TPO_DEFS_SVH
`define TPO_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TPO_OFF_COUNT   8'h00
`define TPO_OFF_CYCLE   8'h04
`define TPO_OFF_DUTY    8'h08
`define TPO_OFF_MODE    8'h0c
`define TPO_OFF_CAPCMP  8'h10
`define TPO_OFF_OUTCTL  8'h14
`define TPO_OFF_PRESC   8'h18

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define TPO_OVF_BIT     0
`define TPO_RUN_LSB     2
`define TPO_RUN_MSB     3
`define TPO_CRC_MSB     2
`define TPO_OE_BIT      0
`define TPO_LVR_BIT     2
`define TPO_LVS_BIT     3
`define TPO_OSE_BIT     5
`define TPO_OSPT_BIT    6
`define TPO_CKS_LSB     0
`define TPO_CKS_MSB     1
`define TPO_ES_LSB      4
`define TPO_ES_MSB      5

// ----------------------------------------------------------------
// encodings and counts
// ----------------------------------------------------------------
`define TPO_ES_FALL     2'h0
`define TPO_ES_RISE     2'h1
`define TPO_ES_BOTH     2'h3
`define TPO_CKS_DIV1    2'h0
`define TPO_CKS_DIV4    2'h1
`define TPO_CKS_DIV256  2'h2
`define TPO_LIM_DIV1    8'h00
`define TPO_LIM_DIV4    8'h03
`define TPO_LIM_DIV256  8'hff
`define TPO_LIM_DIV16   8'h0f
`define TPO_CNT_MAX     16'hffff
`define TPO_CNT_ZERO    16'h0000
`define TPO_CNT_ONE     16'h0001
`define TPO_HSIZE_WORD  3'h2
`define TPO_RST_WORD    32'h0000_0000

`endif

//--- logic/tpo_pkg.sv
// Purpose: types of the 16-bit pulse timer
// Assumes: nothing
// Notes:   run mode values follow the two mode bits
package tpo_pkg;

    typedef enum logic [1:0]
    {
        TPO_RUN_STOP = 2'h0,
        TPO_RUN_EDGE = 2'h1,
        TPO_RUN_FREE = 2'h2,
        TPO_RUN_CYC  = 2'h3
    } tpo_run_t;

    typedef enum logic [2:0]
    {
        TPO_OS_IDLE   = 3'h1,
        TPO_OS_ARMED  = 3'h2,
        TPO_OS_ACTIVE = 3'h4
    } tpo_os_t;

endpackage

//--- logic/tpo_pin_sync.sv
// Purpose: trigger pin synchroniser with agreement filter and edges
// Assumes: pin is asynchronous to core_clk_i
// Notes:   level moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module tpo_pin_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic s1;
    logic s2;
    logic s3;
    logic agree;

    // ----------------------------------------------------------------
    // three stages; s1 feeds s2 only
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (agree)
            begin
                level_o <= s3;
            end
        end
    end

    assign agree = (s2 == s3);
    assign rise_o = agree && s3 && !level_o;
    assign fall_o = agree && !s3 && level_o;

endmodule // tpo_pin_sync

`default_nettype wire

//--- logic/tpo_timer.sv
// Purpose: 16-bit timer with PPG and one-shot pulse output, AHB-Lite slave
// Assumes: single word transfers; zero wait states
// Notes:   compare registers are write/read words; counter is read only
`timescale 1ns/1ps
`default_nettype none
`include "tpo_defs.svh"

module tpo_timer (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         hsel_i,
    input  wire logic [31:0]  haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic [31:0]  hwdata_i,
    input  wire logic         hready_i,
    output logic      [31:0]  hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    input  wire logic         trigger_input_pin_i,
    output logic              pulse_output_pin_o,
    output logic              cycle_match_irq_o,
    output logic              duty_match_irq_o,
    output tpo_pkg::tpo_run_t run_mode_o
);
    import tpo_pkg::*;

    logic [15:0] up_counter;
    logic [15:0] cycle_compare_reg;
    logic [15:0] duty_compare_reg;
    tpo_run_t    run_mode;
    logic        overflow_flag;
    logic [2:0]  capcmp_control_reg;
    logic        out_en;
    logic        os_en;
    logic [1:0]  clk_sel;
    logic [1:0]  edge_sel;
    logic [7:0]  div_cnt;
    logic [7:0]  div_lim;
    logic        tick;
    logic        addr_ok;
    logic        dp_wr;
    logic        dp_rd_cnt;
    logic [7:0]  dp_addr;
    logic [31:0] next_rdata;
    logic        running;
    logic        count_step;
    logic        wrapped;
    tpo_os_t     os_state;
    logic        out_lvl;
    logic        pin_rise;
    logic        pin_fall;
    logic        ext_edge;
    logic        sw_trig;
    logic        trig;
    logic        wr_ctl;
    logic        wr_mode;
    logic        cyc_hit;
    logic        duty_hit;
    logic        cyc_match;
    logic        duty_match;
    logic        start_match;
    logic        end_match;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ----------------------------------------------------------------
    // trigger pin
    // ----------------------------------------------------------------
    tpo_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (trigger_input_pin_i),
        .level_o    (),
        .rise_o     (pin_rise),
        .fall_o     (pin_fall)
    );

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign addr_ok = hsel_i && htrans_i[1] && hready_i;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dp_wr <= 1'b0;
            dp_rd_cnt <= 1'b0;
            dp_addr <= 8'h00;
        end
        else
        begin
            dp_wr <= addr_ok && hwrite_i && (hsize_i == `TPO_HSIZE_WORD);
            dp_rd_cnt <= addr_ok && !hwrite_i && hit(haddr_i[7:0], `TPO_OFF_COUNT);
            dp_addr <= haddr_i[7:0];
        end
    end

    // reading the counter returns it and swallows a tick in its data phase; nothing is captured
    always_comb
    begin
        next_rdata = `TPO_RST_WORD;
        case (haddr_i[7:0])
            `TPO_OFF_COUNT:  next_rdata[15:0] = up_counter;
            `TPO_OFF_CYCLE:  next_rdata[15:0] = cycle_compare_reg;
            `TPO_OFF_DUTY:   next_rdata[15:0] = duty_compare_reg;
            `TPO_OFF_MODE:
            begin
                next_rdata[`TPO_RUN_MSB:`TPO_RUN_LSB] = run_mode;
                next_rdata[`TPO_OVF_BIT] = overflow_flag;
            end
            `TPO_OFF_CAPCMP: next_rdata[`TPO_CRC_MSB:0] = capcmp_control_reg;
            `TPO_OFF_OUTCTL:
            begin
                // level and trigger bits are never stored, so read zero
                next_rdata[`TPO_OE_BIT] = out_en;
                next_rdata[`TPO_OSE_BIT] = os_en;
            end
            `TPO_OFF_PRESC:
            begin
                next_rdata[`TPO_CKS_MSB:`TPO_CKS_LSB] = clk_sel;
                next_rdata[`TPO_ES_MSB:`TPO_ES_LSB] = edge_sel;
            end
            default:         next_rdata = `TPO_RST_WORD;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hrdata_o <= `TPO_RST_WORD;
        end
        else if (addr_ok && !hwrite_i)
        begin
            hrdata_o <= next_rdata;
        end
    end

    assign wr_ctl = dp_wr && hit(dp_addr, `TPO_OFF_OUTCTL);
    assign wr_mode = dp_wr && hit(dp_addr, `TPO_OFF_MODE);

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    // compare values survive a stop here, but are not promised to
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cycle_compare_reg <= `TPO_CNT_ZERO;
            duty_compare_reg <= `TPO_CNT_ZERO;
            run_mode <= TPO_RUN_STOP;
            capcmp_control_reg <= 3'h0;
            out_en <= 1'b0;
            os_en <= 1'b0;
            clk_sel <= 2'h0;
            edge_sel <= 2'h0;
        end
        else if (dp_wr)
        begin
            case (dp_addr)
                `TPO_OFF_CYCLE:  cycle_compare_reg <= hwdata_i[15:0];
                `TPO_OFF_DUTY:   duty_compare_reg <= hwdata_i[15:0];
                `TPO_OFF_MODE:   run_mode <= tpo_run_t'(hwdata_i[`TPO_RUN_MSB:`TPO_RUN_LSB]);
                `TPO_OFF_CAPCMP: capcmp_control_reg <= hwdata_i[`TPO_CRC_MSB:0];
                `TPO_OFF_OUTCTL:
                begin
                    out_en <= hwdata_i[`TPO_OE_BIT];
                    os_en <= hwdata_i[`TPO_OSE_BIT];
                end
                `TPO_OFF_PRESC:
                begin
                    clk_sel <= hwdata_i[`TPO_CKS_MSB:`TPO_CKS_LSB];
                    edge_sel <= hwdata_i[`TPO_ES_MSB:`TPO_ES_LSB];
                end
                default:         run_mode <= run_mode;
            endcase
        end
    end

    assign run_mode_o = run_mode;
    assign running = (run_mode != TPO_RUN_STOP);

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // free running, so a start lands anywhere inside a count period
    always_comb
    begin
        case (clk_sel)
            `TPO_CKS_DIV1:   div_lim = `TPO_LIM_DIV1;
            `TPO_CKS_DIV4:   div_lim = `TPO_LIM_DIV4;
            `TPO_CKS_DIV256: div_lim = `TPO_LIM_DIV256;
            default:         div_lim = `TPO_LIM_DIV16;
        endcase
    end

    assign tick = (div_cnt >= div_lim);

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_cnt <= 8'h00;
        end
        else if (tick)
        begin
            div_cnt <= 8'h00;
        end
        else
        begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // triggers and matches
    // ----------------------------------------------------------------
    // a count read in its data phase swallows that tick
    assign count_step = running && tick && !dp_rd_cnt;

    always_comb
    begin
        case (edge_sel)
            `TPO_ES_FALL: ext_edge = pin_fall;
            `TPO_ES_RISE: ext_edge = pin_rise;
            `TPO_ES_BOTH: ext_edge = pin_rise || pin_fall;
            default:      ext_edge = 1'b0;
        endcase
    end

    // trigger bit ignored outside one-shot mode
    assign sw_trig = wr_ctl && hwdata_i[`TPO_OSPT_BIT] && os_en && running;
    // pin edges stay live in software one-shot mode too
    assign trig = sw_trig
               || (running && ext_edge && (os_en || run_mode == TPO_RUN_EDGE));

    // a zero compare value only matches once the count has wrapped
    assign cyc_hit = (up_counter == cycle_compare_reg)
                  && !(cycle_compare_reg == `TPO_CNT_ZERO && !wrapped);
    assign duty_hit = (up_counter == duty_compare_reg)
                   && !(duty_compare_reg == `TPO_CNT_ZERO && !wrapped);
    assign cyc_match = count_step && cyc_hit && !trig;
    assign duty_match = count_step && duty_hit && !trig;

    // with duty above cycle the two edges swap roles
    assign start_match = (duty_compare_reg < cycle_compare_reg) ? duty_match : cyc_match;
    assign end_match = (duty_compare_reg < cycle_compare_reg) ? cyc_match : duty_match;

    // ----------------------------------------------------------------
    // counter and overflow
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            up_counter <= `TPO_CNT_ZERO;
        end
        else if (!running)
        begin
            up_counter <= `TPO_CNT_ZERO;
        end
        else if (trig)
        begin
            up_counter <= `TPO_CNT_ZERO;
        end
        else if (count_step)
        begin
            if (run_mode == TPO_RUN_CYC && cyc_hit)
            begin
                up_counter <= `TPO_CNT_ZERO;
            end
            else
            begin
                // a compare below the count waits for the wrap
                up_counter <= up_counter + `TPO_CNT_ONE;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wrapped <= 1'b0;
        end
        else if (!running)
        begin
            wrapped <= 1'b0;
        end
        else if (count_step && up_counter == `TPO_CNT_MAX)
        begin
            wrapped <= 1'b1;
        end
    end

    // set beats a clear written in the same cycle
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            overflow_flag <= 1'b0;
        end
        else if (count_step && up_counter == `TPO_CNT_MAX && !trig)
        begin
            overflow_flag <= 1'b1;
        end
        else if (wr_mode)
        begin
            overflow_flag <= hwdata_i[`TPO_OVF_BIT];
        end
    end

    // ----------------------------------------------------------------
    // one-shot sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            os_state <= TPO_OS_IDLE;
        end
        else if (!running || !os_en)
        begin
            os_state <= TPO_OS_IDLE;
        end
        else if (trig)
        begin
            os_state <= TPO_OS_ARMED;
        end
        else
        begin
            case (os_state)
                TPO_OS_IDLE:   os_state <= TPO_OS_IDLE;
                TPO_OS_ARMED:
                begin
                    if (start_match)
                    begin
                        os_state <= TPO_OS_ACTIVE;
                    end
                end
                TPO_OS_ACTIVE:
                begin
                    if (end_match)
                    begin
                        os_state <= TPO_OS_IDLE;
                    end
                end
                default:       os_state <= TPO_OS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output level
    // ----------------------------------------------------------------
    // a retrigger mid-pulse drops the level and restarts
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            out_lvl <= 1'b0;
        end
        else if (wr_ctl && hwdata_i[`TPO_LVS_BIT])
        begin
            out_lvl <= 1'b1;
        end
        else if (wr_ctl && hwdata_i[`TPO_LVR_BIT])
        begin
            out_lvl <= 1'b0;
        end
        else if (os_en)
        begin
            if (trig)
            begin
                out_lvl <= 1'b0;
            end
            else if (os_state == TPO_OS_ARMED && start_match)
            begin
                out_lvl <= 1'b1;
            end
            else if (os_state == TPO_OS_ACTIVE && end_match)
            begin
                out_lvl <= 1'b0;
            end
        end
        else if (run_mode == TPO_RUN_CYC)
        begin
            if (cyc_match)
            begin
                out_lvl <= 1'b1;
            end
            else if (duty_match)
            begin
                out_lvl <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pulse_output_pin_o <= 1'b0;
            cycle_match_irq_o <= 1'b0;
            duty_match_irq_o <= 1'b0;
        end
        else
        begin
            pulse_output_pin_o <= out_en && out_lvl;
            cycle_match_irq_o <= cyc_match;
            duty_match_irq_o <= duty_match;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_wrap;
        count_step && up_counter == `TPO_CNT_MAX && !trig;
    endsequence

    sequence s_ctl_read;
        addr_ok && !hwrite_i && hit(haddr_i[7:0], `TPO_OFF_OUTCTL);
    endsequence

    property p_ovf;
        s_wrap |=> overflow_flag && up_counter == `TPO_CNT_ZERO;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged on wrap");

    property p_stop;
        !running |=> up_counter == `TPO_CNT_ZERO;
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_trig;
        trig |=> up_counter == `TPO_CNT_ZERO;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not clear count");

    property p_cyc_clear;
        count_step && run_mode == TPO_RUN_CYC && cyc_hit && !trig
            |=> up_counter == `TPO_CNT_ZERO ##1 cycle_match_irq_o == 1'b0;
    endproperty
    a_cyc_clear: assert property (p_cyc_clear) else $error("cycle match no clear");

    property p_pause;
        dp_rd_cnt && running && !trig |=> $stable(up_counter);
    endproperty
    a_pause: assert property (p_pause) else $error("count moved during read");

    property p_ctl_rd;
        s_ctl_read |=> hrdata_o[`TPO_LVS_BIT] == 1'b0 && hrdata_o[`TPO_LVR_BIT] == 1'b0
                       && hrdata_o[`TPO_OSPT_BIT] == 1'b0;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("level or trigger bit read one");

    property p_os_on;
        os_state == TPO_OS_ARMED && start_match && !wr_ctl
            |=> out_lvl ##1 pulse_output_pin_o == out_en;
    endproperty
    a_os_on: assert property (p_os_on) else $error("one-shot did not go active");

    property p_os_rev;
        os_state == TPO_OS_ACTIVE && duty_match && !wr_ctl
            && duty_compare_reg > cycle_compare_reg |=> !out_lvl;
    endproperty
    a_os_rev: assert property (p_os_rev) else $error("duty match did not end pulse");

    property p_zero;
        duty_match && duty_compare_reg == `TPO_CNT_ZERO |-> wrapped;
    endproperty
    a_zero: assert property (p_zero) else $error("zero compare matched before wrap");

    property p_irq_stop;
        !running ##1 !running |-> !cycle_match_irq_o && !duty_match_irq_o;
    endproperty
    a_irq_stop: assert property (p_irq_stop) else $error("match event while stopped");

endmodule // tpo_timer

`default_nettype wire

//--- verification/tpo_pin_model.sv
// Purpose: far side of the timer pins
// Assumes: trigger pin is a driven level
// Notes:   counts output high cycles and rises
`timescale 1ns/1ps
`default_nettype none

module tpo_pin_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        lvl_i,
    input  wire logic        pulse_i,
    output logic             pin_o,
    output logic [15:0]      hi_o,
    output logic [15:0]      rise_o
);
    logic prev;

    // pin follows the bench level directly, at any time
    assign pin_o = lvl_i;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hi_o   <= 16'h0;
            rise_o <= 16'h0;
            prev   <= 1'b0;
        end
        else
        begin
            prev   <= pulse_i;
            hi_o   <= hi_o + {15'h0, pulse_i};
            rise_o <= rise_o + {15'h0, pulse_i & ~prev};
        end
    end
endmodule // tpo_pin_model
`default_nettype wire

//--- verification/timer_ppg_oneshot_output_tb.sv
// Purpose: self-checking bench of the pulse timer
// Assumes: one clock, AHB-Lite master in the bench
// Notes:   one-shot rows packed as hex nibbles
`timescale 1ns/1ps
`default_nettype none

module timer_ppg_oneshot_output_tb;
    import tpo_pkg::*;
    logic        clk, rst, hsel, hwrite, lvl, pin;
    logic        hready, hresp, pout, cirq, dirq;
    logic [31:0] haddr, hwdata, hrdata, rd, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    tpo_run_t    run;
    logic [15:0] hi, h0, rs, r0;
    int          n_fail, tests_run, i;
    logic [7:0]  ra [8] = '{8'h04, 8'h08, 8'h18, 8'h14, 8'h10, 8'h00, 8'h20, 8'h0c};
    logic [7:0]  wd [8] = '{8'h03, 8'h01, 8'h30, 8'h2d, 8'h07, 8'h55, 8'hff, 8'h00};
    logic [7:0]  ex [8] = '{8'h03, 8'h01, 8'h30, 8'h21, 8'h07, 8'h00, 8'h00, 8'h00};
    // mode, edge, pin start, pin end, soft trigger, cycle, duty, width
    logic [31:0] osr [7] = '{32'h81001835, 32'h81001385, 32'h81010835,
        32'h40100835, 32'h41010835, 32'h43100835, 32'h42010830};

    tpo_timer dut (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .trigger_input_pin_i(pin), .pulse_output_pin_o(pout),
        .cycle_match_irq_o(cirq), .duty_match_irq_o(dirq), .run_mode_o(run));
    tpo_pin_model far (.clk_i(clk), .rst_i(rst), .lvl_i(lvl), .pulse_i(pout),
        .pin_o(pin), .hi_o(hi), .rise_o(rs));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // holds each phase until hready is seen high at an edge
    task automatic rdy;
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 50)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial
    begin
        {rst, hsel, hwrite, lvl, haddr, hwdata, htrans} = '0;
        rst = 1'b1;
        hsize = 3'h2;
        n_fail = 0;
        tests_run = 0;
        wt(3);
        rst <= 1'b0;
        wt(1);
        chk({28'h0, pout, cirq, dirq, hresp} | {30'h0, run}, 0);
        $display("reset test done");
        for (i = 0; i < 8; i++)
        begin
            bus(1, ra[i], {24'h0, wd[i]});
            bus(0, ra[i], 0);
            chk(rd, {24'h0, ex[i]});
        end
        $display("register test done");
        for (i = 0; i < 7; i++)
        begin
            r = osr[i];
            bus(1, 8'h0c, 0); // stopped before setup
            bus(1, 8'h14, 32'h25);
            bus(1, 8'h18, {26'h0, r[25:24], 4'h0});
            bus(1, 8'h04, {28'h0, r[11:8]}); // nonzero, never equal
            bus(1, 8'h08, {28'h0, r[7:4]});
            lvl <= r[20];
            wt(8);
            bus(1, 8'h0c, {28'h0, r[31:28]});
            h0 = hi;
            if (r[12])
                bus(1, 8'h14, 32'h61); // single trigger
            else
                lvl <= r[16];
            wt(40);
            chk({16'h0, hi - h0}, {28'h0, r[3:0]});
            bus(0, 8'h14, 0);
            chk(rd, 32'h21);
            bus(0, 8'h00, 0);
            chk({31'h0, rd[15:0] > 16'h8}, 1);
        end
        $display("one-shot test done");
        bus(1, 8'h0c, 0);
        wt(1);
        chk({30'h0, run}, {30'h0, TPO_RUN_STOP});
        h0 = hi;
        lvl <= ~lvl;
        wt(10);
        bus(0, 8'h00, 0);
        chk(rd | {16'h0, hi - h0}, 0);
        $display("stop test done");
        bus(1, 8'h14, 32'h05);
        bus(1, 8'h18, 0);
        bus(1, 8'h04, 32'h3); // duty below cycle, nonzero cycle
        bus(1, 8'h08, 32'h1);
        bus(1, 8'h0c, 32'h0c);
        wt(1);
        chk({30'h0, run}, {30'h0, TPO_RUN_CYC});
        wt(8);
        h0 = hi;
        r0 = rs;
        wt(40);
        chk({hi - h0, rs - r0}, {16'h0014, 16'h000a});
        i = 0;
        while (cirq !== 1'b1 && i < 8)
        begin
            wt(1);
            i++;
        end
        chk({30'h0, cirq, dirq}, 32'h2);
        $display("pulse train test done");
        bus(1, 8'h0c, 0); // stopped before setup
        bus(1, 8'h18, 32'h01);
        bus(1, 8'h0c, 32'h0c);
        wt(24);
        h0 = hi;
        r0 = rs;
        wt(64);
        chk({hi - h0, rs - r0}, {16'h0020, 16'h0004});
        $display("prescaled pulse train test done");
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        wt(1);
        chk({28'h0, pout, cirq, dirq, hresp} | {30'h0, run}, 0);
        bus(0, 8'h04, 0);
        chk(rd, 0);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule // timer_ppg_oneshot_output_tb
`default_nettype wire
